// ### hw/ips_pkg.sv
`default_nettype none
package ips_pkg;
	// ****************************************
	// sizes
	// ****************************************
	localparam int NUM_SRC     = 18;
	localparam int LVL_W       = 2;
	localparam int NUM_REGS    = 6;
	localparam int REG_IDX_W   = 3;
	localparam int PC_W        = 16;

	// ****************************************
	// register indices, byte address is index x 4
	// ****************************************
	localparam logic [7:0] IDX_BASE_LOW   = 8'hB8;
	localparam logic [7:0] IDX_BASE_HIGH  = 8'hB7;
	localparam logic [7:0] IDX_EXT_LOW_A  = 8'hEF;
	localparam logic [7:0] IDX_EXT_HIGH_A = 8'hF7;
	localparam logic [7:0] IDX_EXT_LOW_B  = 8'hFE;
	localparam logic [7:0] IDX_EXT_HIGH_B = 8'hFF;
	localparam logic [7:0] IDX_STATUS     = 8'hC0;
	localparam logic [7:0] IDX_CTRL       = 8'hC1;
	localparam logic [7:0] IDX_VECTOR     = 8'hC2;

	// ****************************************
	// writable masks and reset values
	// ****************************************
	localparam logic [7:0] MASK_BASE   = 8'h7F;
	localparam logic [7:0] MASK_EXT_A  = 8'hFF;
	localparam logic [7:0] MASK_EXT_B  = 8'h07;
	localparam logic [7:0] RST_PRIO    = 8'h00;

	// ****************************************
	// timing
	// ****************************************
	localparam int CALL_CYCLES  = 4;
	localparam int EXIT_CYCLES  = 5;
	localparam int LONG_INSN    = 6;
	localparam int DETECT_CYC   = 1;
	localparam int WORST_LAT    = EXIT_CYCLES + LONG_INSN + DETECT_CYC + CALL_CYCLES;

	// ****************************************
	// source numbering (natural order, 0 best)
	// ****************************************
	localparam int SRC_EXT0  = 0;
	localparam int SRC_BOD   = 1;
	localparam int SRC_WDT   = 2;
	localparam int SRC_T0    = 3;
	localparam int SRC_TWI   = 4;
	localparam int SRC_ADC   = 5;
	localparam int SRC_EXT1  = 6;
	localparam int SRC_PIN   = 7;
	localparam int SRC_T1    = 8;
	localparam int SRC_SER0  = 9;
	localparam int SRC_BRAKE = 10;
	localparam int SRC_SPI   = 11;
	localparam int SRC_T2    = 12;
	localparam int SRC_CAP   = 13;
	localparam int SRC_PWM   = 14;
	localparam int SRC_SER1  = 15;
	localparam int SRC_T3    = 16;
	localparam int SRC_WAKE  = 17;

	localparam logic [PC_W-1:0] VEC_TABLE [NUM_SRC] = '{
		16'h0003, 16'h0043, 16'h0053, 16'h000B, 16'h0033, 16'h005B,
		16'h0013, 16'h003B, 16'h001B, 16'h0023, 16'h0073, 16'h004B,
		16'h002B, 16'h0063, 16'h006B, 16'h007B, 16'h0083, 16'h008B};

	typedef enum logic [1:0] {
		IPS_IDLE,
		IPS_CALL
	} ips_state_t;
endpackage
`default_nettype wire

// ### hw/ips_call_if.sv
`default_nettype none
interface ips_call_if;
	logic                      start;
	logic [ips_pkg::PC_W-1:0]  vector;
	logic                      busy;
	logic                      done;
	modport ctl (output start, output vector, input busy, input done);
	modport seq (input start, input vector, output busy, output done);
endinterface
`default_nettype wire

// ### hw/ips_call_seq.sv
`default_nettype none
// hardware vector call sequencer: push pc, load vector
module ips_call_seq
	import ips_pkg::*;
(
	input  wire logic            clk_sys,
	input  wire logic            rst,
	ips_call_if.seq              call,
	output logic                 push_req,
	output logic                 load_pc,
	output logic [PC_W-1:0]      load_addr
);
	typedef struct packed {
		ips_state_t      st;
		logic [2:0]      cnt;
		logic [PC_W-1:0] vec;
		logic            push;
		logic            load;
	} ips_seq_t;

	ips_seq_t cur_ff;
	ips_seq_t nxt_cur;

	always_comb begin
		nxt_cur      = cur_ff;
		nxt_cur.push = 1'b0;
		nxt_cur.load = 1'b0;
		case (cur_ff.st)
			IPS_IDLE: begin
				if (call.start) begin
					nxt_cur.st   = IPS_CALL;
					nxt_cur.cnt  = 3'(CALL_CYCLES - 1);
					nxt_cur.vec  = call.vector;
					nxt_cur.push = 1'b1;
				end
			end
			IPS_CALL: begin
				if (cur_ff.cnt == 3'h1) begin
					nxt_cur.load = 1'b1;
				end
				if (cur_ff.cnt == 3'h0) begin
					nxt_cur.st = IPS_IDLE;
				end else begin
					nxt_cur.cnt = cur_ff.cnt - 3'h1;
				end
			end
			default: nxt_cur.st = IPS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign call.busy = (cur_ff.st == IPS_CALL);
	assign call.done = (cur_ff.st == IPS_CALL) && (cur_ff.cnt == 3'h0);
	assign push_req  = cur_ff.push;
	assign load_pc   = cur_ff.load;
	assign load_addr = cur_ff.vec;
endmodule
`default_nettype wire

// ### hw/ips_ctrl.sv
`default_nettype none
module ips_ctrl
	import ips_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic                  hsel,
	input  wire logic                  hready,
	input  wire logic [31:0]           hwdata,
	output logic [31:0]                hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire logic [ips_pkg::NUM_SRC-1:0] irq_flags,
	input  wire logic                  insn_last,
	input  wire logic                  insn_writes_ie,
	input  wire logic                  insn_is_isr_exit,
	output logic                       call_push,
	output logic                       call_load_pc,
	output logic [ips_pkg::PC_W-1:0]   call_vector,
	output logic                       call_busy,
	output logic [ips_pkg::NUM_SRC-1:0] call_ack
);
	import ips_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0]         base_low;
		logic [7:0]         base_high;
		logic [7:0]         ext_low_a;
		logic [7:0]         ext_high_a;
		logic [7:0]         ext_low_b;
		logic [7:0]         ext_high_b;
		logic [3:0]         in_service;
		logic               wr_pend;
		logic [7:0]         wr_addr;
		logic [31:0]        rdata;
		logic [PC_W-1:0]    last_vec;
		logic [4:0]         last_src;
		logic               stall_ie;
		logic [NUM_SRC-1:0] ack;
	} ips_ctl_t;

	ips_ctl_t cur_ff;
	ips_ctl_t nxt_cur;

	ips_call_if call_bus ();

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] word_index(input logic [31:0] a);
		word_index = a[9:2];
	endfunction

	function automatic logic [7:0] write_mask(input logic [7:0] idx);
		case (idx)
			IDX_BASE_LOW,
			IDX_BASE_HIGH:  write_mask = MASK_BASE;
			IDX_EXT_LOW_A,
			IDX_EXT_HIGH_A: write_mask = MASK_EXT_A;
			IDX_EXT_LOW_B,
			IDX_EXT_HIGH_B: write_mask = MASK_EXT_B;
			default:        write_mask = 8'h00;
		endcase
	endfunction

	function automatic logic [1:0] lvl(input logic hi, input logic lo);
		lvl = {hi, lo};
	endfunction

	// ****************************************
	// per-source levels
	// ****************************************
	logic [LVL_W-1:0] src_lvl [NUM_SRC];

	always_comb begin
		src_lvl[SRC_EXT0]  = lvl(cur_ff.base_high[0], cur_ff.base_low[0]);
		src_lvl[SRC_T0]    = lvl(cur_ff.base_high[1], cur_ff.base_low[1]);
		src_lvl[SRC_EXT1]  = lvl(cur_ff.base_high[2], cur_ff.base_low[2]);
		src_lvl[SRC_T1]    = lvl(cur_ff.base_high[3], cur_ff.base_low[3]);
		src_lvl[SRC_SER0]  = lvl(cur_ff.base_high[4], cur_ff.base_low[4]);
		src_lvl[SRC_BOD]   = lvl(cur_ff.base_high[5], cur_ff.base_low[5]);
		src_lvl[SRC_ADC]   = lvl(cur_ff.base_high[6], cur_ff.base_low[6]);
		src_lvl[SRC_TWI]   = lvl(cur_ff.ext_high_a[0], cur_ff.ext_low_a[0]);
		src_lvl[SRC_PIN]   = lvl(cur_ff.ext_high_a[1], cur_ff.ext_low_a[1]);
		src_lvl[SRC_CAP]   = lvl(cur_ff.ext_high_a[2], cur_ff.ext_low_a[2]);
		src_lvl[SRC_PWM]   = lvl(cur_ff.ext_high_a[3], cur_ff.ext_low_a[3]);
		src_lvl[SRC_WDT]   = lvl(cur_ff.ext_high_a[4], cur_ff.ext_low_a[4]);
		src_lvl[SRC_BRAKE] = lvl(cur_ff.ext_high_a[5], cur_ff.ext_low_a[5]);
		src_lvl[SRC_SPI]   = lvl(cur_ff.ext_high_a[6], cur_ff.ext_low_a[6]);
		src_lvl[SRC_T2]    = lvl(cur_ff.ext_high_a[7], cur_ff.ext_low_a[7]);
		src_lvl[SRC_SER1]  = lvl(cur_ff.ext_high_b[0], cur_ff.ext_low_b[0]);
		src_lvl[SRC_T3]    = lvl(cur_ff.ext_high_b[1], cur_ff.ext_low_b[1]);
		src_lvl[SRC_WAKE]  = lvl(cur_ff.ext_high_b[2], cur_ff.ext_low_b[2]);
	end

	// ****************************************
	// poll and resolve
	// ****************************************
	logic             win_valid;
	logic [4:0]       win_src;
	logic [LVL_W-1:0] win_lvl;
	logic [LVL_W-1:0] busy_lvl;
	logic             any_busy;
	logic             grant;

	// combinational poll every cycle; live flags only
	always_comb begin
		win_valid = 1'b0;
		win_src   = 5'h00;
		win_lvl   = 2'h0;
		for (int i = 0; i < NUM_SRC; i++) begin
			// strict greater keeps natural order on ties
			if (irq_flags[i] && (!win_valid || src_lvl[i] > win_lvl)) begin
				win_valid = 1'b1;
				win_src   = 5'(i);
				win_lvl   = src_lvl[i];
			end
		end
	end

	always_comb begin
		any_busy = |cur_ff.in_service;
		busy_lvl = 2'h0;
		for (int l = 0; l < 4; l++) begin
			if (cur_ff.in_service[l]) begin
				busy_lvl = 2'(l);
			end
		end
	end

	assign grant = win_valid
		&& (!any_busy || win_lvl > busy_lvl)
		&& insn_last
		&& !insn_writes_ie
		&& !cur_ff.stall_ie
		&& !insn_is_isr_exit
		&& !call_bus.busy;

	assign call_bus.start  = grant;
	assign call_bus.vector = VEC_TABLE[win_src];

	// ****************************************
	// next state
	// ****************************************
	logic       bus_go;
	logic [7:0] cur_idx;

	assign bus_go  = hsel && hready && htrans[1];
	assign cur_idx = cur_ff.wr_addr;

	always_comb begin
		nxt_cur          = cur_ff;
		nxt_cur.wr_pend  = 1'b0;
		nxt_cur.ack      = '0;
		nxt_cur.stall_ie = 1'b0;
		if (cur_ff.wr_pend) begin
			case (cur_idx)
				IDX_BASE_LOW:   nxt_cur.base_low   = hwdata[7:0] & write_mask(cur_idx);
				IDX_BASE_HIGH:  nxt_cur.base_high  = hwdata[7:0] & write_mask(cur_idx);
				IDX_EXT_LOW_A:  nxt_cur.ext_low_a  = hwdata[7:0] & write_mask(cur_idx);
				IDX_EXT_HIGH_A: nxt_cur.ext_high_a = hwdata[7:0] & write_mask(cur_idx);
				IDX_EXT_LOW_B:  nxt_cur.ext_low_b  = hwdata[7:0] & write_mask(cur_idx);
				IDX_EXT_HIGH_B: nxt_cur.ext_high_b = hwdata[7:0] & write_mask(cur_idx);
				default: ;
			endcase
			// priority write blocks next boundary too
			nxt_cur.stall_ie = (write_mask(cur_idx) != 8'h00);
		end
		if (bus_go) begin
			nxt_cur.wr_pend = hwrite;
			nxt_cur.wr_addr = word_index(haddr);
			case (word_index(haddr))
				IDX_BASE_LOW:   nxt_cur.rdata = {24'h000000, cur_ff.base_low};
				IDX_BASE_HIGH:  nxt_cur.rdata = {24'h000000, cur_ff.base_high};
				IDX_EXT_LOW_A:  nxt_cur.rdata = {24'h000000, cur_ff.ext_low_a};
				IDX_EXT_HIGH_A: nxt_cur.rdata = {24'h000000, cur_ff.ext_high_a};
				IDX_EXT_LOW_B:  nxt_cur.rdata = {24'h000000, cur_ff.ext_low_b};
				IDX_EXT_HIGH_B: nxt_cur.rdata = {24'h000000, cur_ff.ext_high_b};
				IDX_STATUS:     nxt_cur.rdata = {19'h00000, cur_ff.last_src, 4'h0, cur_ff.in_service};
				IDX_VECTOR:     nxt_cur.rdata = {16'h0000, cur_ff.last_vec};
				default:        nxt_cur.rdata = 32'h00000000;
			endcase
		end
		if (grant) begin
			// per-source ack, flags cleared by sources themselves
			nxt_cur.ack[win_src]            = 1'b1;
			nxt_cur.in_service[win_lvl]     = 1'b1;
			nxt_cur.last_vec                = VEC_TABLE[win_src];
			nxt_cur.last_src                = win_src;
		end else if (insn_last && insn_is_isr_exit && any_busy) begin
			// interrupt return clears top level; plain return never reaches here
			nxt_cur.in_service[busy_lvl] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ****************************************
	// call sequencer
	// ****************************************
	// push then load over four cycles
	// one detect cycle, then the call
	ips_call_seq u_seq (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.call      (call_bus.seq),
		.push_req  (call_push),
		.load_pc   (call_load_pc),
		.load_addr (call_vector)
	);

	// return address is the core's business, no check here
	assign call_busy = call_bus.busy;
	assign call_ack  = cur_ff.ack;
	assign hrdata    = cur_ff.rdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
endmodule
`default_nettype wire

// ### verification/ips_checker.sv
`default_nettype none
module ips_checker (
	input wire logic                      clk_sys,
	input wire logic                      rst,
	input wire logic [ips_pkg::NUM_SRC-1:0] irq_flags,
	input wire logic                      insn_last,
	input wire logic                      insn_writes_ie,
	input wire logic                      insn_is_isr_exit,
	input wire logic                      call_push,
	input wire logic                      call_load_pc,
	input wire logic                      call_busy,
	input wire logic [ips_pkg::NUM_SRC-1:0] call_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	import ips_pkg::*;
	// ****
	// grant and call sequence
	// ****
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	ack_onehot_a: assert property ($onehot0(call_ack))
		else $error("more than one source granted");
	ack_push_a: assert property ((call_ack != '0) |-> call_push)
		else $error("grant without push");
	push_load_a: assert property (call_push |-> !call_load_pc ##3 call_load_pc)
		else $error("pc load not three cycles after push");
	call_len_a: assert property (call_push |-> call_busy[*4] ##1 !call_busy)
		else $error("call not four cycles long");
	load_once_a: assert property (call_load_pc |=> !call_load_pc)
		else $error("pc load longer than one cycle");
	ack_cause_a: assert property ((call_ack != '0) |-> $past(insn_last) && !$past(insn_writes_ie))
		else $error("grant off last cycle or after enable write");
	ack_exit_a: assert property ((call_ack != '0) |-> !$past(insn_is_isr_exit))
		else $error("grant in return cycle");
	ack_flag_a: assert property ((call_ack != '0) |-> (call_ack & ~$past(irq_flags)) == '0)
		else $error("grant for inactive flag");
	ack_idle_a: assert property ((call_ack != '0) |-> !$past(call_busy))
		else $error("grant during a call");
endmodule

bind ips_ctrl ips_checker u_chk (.clk_sys(clk_sys), .rst(rst), .irq_flags(irq_flags), .insn_last(insn_last),
	.insn_writes_ie(insn_writes_ie), .insn_is_isr_exit(insn_is_isr_exit), .call_push(call_push),
	.call_load_pc(call_load_pc), .call_busy(call_busy), .call_ack(call_ack));
`default_nettype wire

// ### verification/ips_core_model.sv
`default_nettype none
// cpu sequencer and stack behind the controller
module ips_core_model (
	input wire logic                     clk_sys,
	input wire logic                     rst,
	input wire logic                     call_push,
	input wire logic                     call_load_pc,
	input wire logic [ips_pkg::PC_W-1:0] call_vector,
	input wire logic                     call_busy,
	input wire logic [2:0]               insn_len,
	input wire logic                     want_isr_exit,
	input wire logic                     want_ie,
	output logic                         insn_last,
	output logic                         insn_writes_ie,
	output logic                         insn_is_isr_exit,
	output logic [ips_pkg::PC_W-1:0]     pc_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	import ips_pkg::*;
	logic [2:0]      cnt_ff;
	logic [2:0]      sp_ff;
	logic [PC_W-1:0] stack_ff [8];

	// no instruction runs while a call is busy
	assign insn_last      = !call_busy && (cnt_ff == insn_len - 3'h1);
	assign insn_writes_ie = want_ie;
	assign insn_is_isr_exit = want_isr_exit;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_ff <= 3'h0;
			sp_ff <= 3'h0;
			pc_ff <= 16'h0100;
		end else if (call_push) begin
			stack_ff[sp_ff] <= pc_ff;
			sp_ff <= sp_ff + 3'h1;
		end else if (call_load_pc) begin
			pc_ff <= call_vector;
		end else if (insn_last) begin
			cnt_ff <= 3'h0;
			if (want_isr_exit) begin
				pc_ff <= stack_ff[sp_ff - 3'h1];
				sp_ff <= sp_ff - 3'h1;
			end else begin
				pc_ff <= pc_ff + 16'h1;
			end
		end else if (!call_busy) begin
			cnt_ff <= cnt_ff + 3'h1;
		end
	end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ips_pkg::*;
	logic                clk_sys = 1'b0;
	logic                rst = 1'b1;
	logic                hwrite = 1'b0;
	logic                want_isr_exit = 1'b0;
	logic                want_ie = 1'b0;
	logic [31:0]         haddr = '0;
	logic [31:0]         hwdata = '0;
	logic [31:0]         hrdata;
	logic [31:0]         rd;
	logic [1:0]          htrans = 2'h0;
	logic [NUM_SRC-1:0]  irq_flags = '0;
	logic [NUM_SRC-1:0]  call_ack;
	logic [2:0]          insn_len = 3'h1;
	logic [PC_W-1:0]     call_vector;
	logic [PC_W-1:0]     pc;
	logic [PC_W-1:0]     back_pc;
	logic [PC_W-1:0]     outer_pc;
	logic                hreadyout;
	logic                hresp;
	logic                insn_last;
	logic                insn_writes_ie;
	logic                insn_is_isr_exit;
	logic                call_push;
	logic                call_load_pc;
	logic                call_busy;
	int                  n_mismatch = 0;
	int                  compares = 0;
	int                  lat = 0;
	localparam logic [7:0] ADR [7] = '{IDX_BASE_LOW, IDX_BASE_HIGH, IDX_EXT_LOW_A, IDX_EXT_HIGH_A,
		IDX_EXT_LOW_B, IDX_EXT_HIGH_B, 8'h10};
	localparam logic [7:0] MSK [7] = '{MASK_BASE, MASK_BASE, MASK_EXT_A, MASK_EXT_A, MASK_EXT_B, MASK_EXT_B, 8'h00};

	always #5 clk_sys = ~clk_sys;

	ips_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hsel(1'b1), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.irq_flags(irq_flags), .insn_last(insn_last), .insn_writes_ie(insn_writes_ie),
		.insn_is_isr_exit(insn_is_isr_exit),
		.call_push(call_push), .call_load_pc(call_load_pc), .call_vector(call_vector), .call_busy(call_busy),
		.call_ack(call_ack));
	ips_core_model CPU (.clk_sys(clk_sys), .rst(rst), .call_push(call_push), .call_load_pc(call_load_pc),
		.call_vector(call_vector), .call_busy(call_busy), .insn_len(insn_len), .want_isr_exit(want_isr_exit),
		.want_ie(want_ie), .insn_last(insn_last), .insn_writes_ie(insn_writes_ie),
		.insn_is_isr_exit(insn_is_isr_exit), .pc_ff(pc));

	// ****
	// tasks
	// ****
	function automatic logic [NUM_SRC-1:0] bit_of(input int s);
		return NUM_SRC'(1) << s;
	endfunction

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic close_out();
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] q);
		@(posedge clk_sys);
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic grant(input int src);
		lat = 0;
		do begin
			@(negedge clk_sys);
			lat++;
		end while (call_ack === '0 && lat < 40);
		chk("granted source", call_ack, bit_of(src));
		back_pc = pc;
		@(posedge clk_sys);
		irq_flags[src] <= 1'b0;
		do begin
			@(negedge clk_sys);
			lat++;
		end while (call_load_pc !== 1'b1 && lat < 80);
		chk("call vector", call_vector, VEC_TABLE[src]);
		@(negedge clk_sys);
		chk("pc at vector", pc, VEC_TABLE[src]);
	endtask

	task automatic isr_exit(input logic [PC_W-1:0] exp);
		@(posedge clk_sys);
		want_isr_exit <= 1'b1;
		do @(negedge clk_sys); while (insn_last !== 1'b1);
		@(posedge clk_sys);
		want_isr_exit <= 1'b0;
		@(negedge clk_sys);
		chk("return pc", pc, exp);
	endtask

	task automatic quiet(input int n);
		repeat (n) begin
			@(negedge clk_sys);
			chk("no grant", call_ack, 0);
		end
	endtask

	// ****
	// tests
	// ****
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		for (int k = 0; k < 7; k++) begin
			bus(1'b0, ADR[k], 0, rd);
			chk("reset value", rd, RST_PRIO);
			bus(1'b1, ADR[k], 32'hFFFFFFFF, rd);
			bus(1'b0, ADR[k], 0, rd);
			chk("masked readback", rd, MSK[k]);
			bus(1'b1, ADR[k], 0, rd);
		end
		bus(1'b1, IDX_EXT_HIGH_A, 32'h81, rd);
		bus(1'b1, IDX_EXT_LOW_A, 32'h80, rd);
		bus(1'b1, IDX_EXT_LOW_B, 32'h01, rd);
		@(posedge clk_sys);
		irq_flags <= bit_of(SRC_T0) | bit_of(SRC_EXT1);
		grant(SRC_T0);
		chk("service latency", lat, DETECT_CYC + CALL_CYCLES);
		isr_exit(back_pc);
		grant(SRC_EXT1);
		isr_exit(back_pc);
		@(posedge clk_sys);
		irq_flags <= bit_of(SRC_TWI) | bit_of(SRC_SER1) | bit_of(SRC_EXT0);
		grant(SRC_TWI);
		outer_pc = back_pc;
		quiet(8);
		@(posedge clk_sys);
		irq_flags[SRC_T2] <= 1'b1;
		grant(SRC_T2);
		isr_exit(back_pc);
		@(posedge clk_sys);
		irq_flags <= '0;
		isr_exit(outer_pc);
		quiet(8);
		@(posedge clk_sys);
		want_ie <= 1'b1;
		irq_flags <= bit_of(SRC_EXT0);
		quiet(6);
		@(posedge clk_sys);
		want_ie <= 1'b0;
		grant(SRC_EXT0);
		isr_exit(back_pc);
		@(posedge clk_sys);
		insn_len <= 3'h6;
		irq_flags <= bit_of(SRC_WAKE);
		grant(SRC_WAKE);
		chk("service latency", lat, LONG_INSN - 1 + DETECT_CYC + CALL_CYCLES);
		chk("latency bound", lat <= WORST_LAT, 1);
		isr_exit(back_pc);
		close_out();
	end

	initial begin
		repeat (3000) @(posedge clk_sys);
		n_mismatch++;
		close_out();
	end
endmodule
`default_nettype wire
